/* verilog/agc_pkg.sv */
// Constants and carrier types for the record-path automatic gain control.
// Assumes one clock domain and a register port driven by the serial
// control interface decoder.
package agc_pkg;

  // Register offsets as seen on the control interface.
  localparam logic [7:0] ADDR_ENABLE_TARGET = 8'h56;
  localparam logic [7:0] ADDR_HYST_NOISE = 8'h57;
  localparam logic [7:0] ADDR_GAIN_CEILING = 8'h58;
  localparam logic [7:0] ADDR_ATTACK = 8'h59;

  // Reset values.
  localparam logic [7:0] RST_ENABLE_TARGET = 8'h00;
  localparam logic [7:0] RST_HYST_NOISE = 8'h00;
  localparam logic [7:0] RST_GAIN_CEILING = 8'h7F;
  localparam logic [7:0] RST_ATTACK = 8'h00;

  // Field positions.
  localparam int ENABLE_BIT = 7;
  localparam int TARGET_LSB = 4;
  localparam int HYST_LSB = 6;
  localparam int NOISE_LSB = 1;
  localparam int ATTACK_N_LSB = 3;
  localparam int ATTACK_M_LSB = 0;

  // Levels are attenuation below full scale in 0.5 dB steps.
  localparam logic [7:0] TARGET_HALF_DB [8] = '{
    8'h0B, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h22, 8'h28, 8'h30};
  localparam logic [7:0] HYST_HALF_DB [4] = '{8'h02, 8'h04, 8'h08, 8'h00};
  // Noise threshold for code N is 56 + 4*N half-dB (-30 dB at N = 1).
  localparam logic [7:0] NOISE_BASE_HALF_DB = 8'h38;

  // Attack unit is 32 sample periods; width covers 63 * 32 * 128.
  localparam int ATTACK_UNIT_SHIFT = 5;
  localparam int ATTACK_CNT_W = 18;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_type;

  typedef enum logic [1:0] {
    ST_OFF = 2'b01,
    ST_TRACK = 2'b10
  } agc_state_type;

endpackage

/* verilog/attack_timer.sv */
// Sample-period interval timer used to pace gain steps.
// Assumes tick is a one-clock pulse per ADC sample on the same clock.
`timescale 1ns/1ps
module attack_timer #(
  parameter int W = 18
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Control.
  input wire logic run,
  input wire logic tick,
  input wire logic [W-1:0] length,
  // Interval elapsed, one clock.
  output logic expire
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic expire_r;
  wire last = (count_r + {{(W-1){1'b0}}, 1'b1}) >= length;

  assign count_nxt = !run ? '0 : !tick ? count_r : last ? '0 :
                     count_r + {{(W-1){1'b0}}, 1'b1};
  assign expire = expire_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      count_r <= '0;
      expire_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      expire_r <= run && tick && last;
    end
  end

endmodule

/* verilog/agc_core.sv */
// Automatic gain control for the mono record path: four control
// registers and the gain tracking loop.
// Assumes the control interface decoder, the level detector and the
// sample strobe all run on clock.
//
// What this block does
// - Top bit of first register enables gain control.
// - Three-bit code picks one of eight target levels.
// - Two-bit hysteresis: 1, 2, 4 dB or none.
// - Noise threshold code zero disables, else -30..-90dB.
// - Seven-bit ceiling caps gain, 0.5 dB steps.
// - Attack time is (2N+1) times 32 samples.
// - Attack multiplier scales time by two to code.
`timescale 1ns/1ps
module agc_core
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Register port.
  input wire logic wr_en,
  input wire agc_pkg::reg_wr_type wr,
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data,
  // Record path.
  input wire logic sample_tick,
  input wire logic [7:0] level,
  // Applied gain in 0.5 dB steps and status.
  output logic [6:0] gain,
  output logic noise_hold,
  output logic active
);

  import agc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0] enable_target_r;
  logic [7:0] hyst_noise_r;
  logic [7:0] gain_ceiling_r;
  logic [7:0] attack_r;
  logic [7:0] rd_data_r;

  wire wr_et = wr_en && wr.addr == ADDR_ENABLE_TARGET;
  wire wr_hn = wr_en && wr.addr == ADDR_HYST_NOISE;
  wire wr_gc = wr_en && wr.addr == ADDR_GAIN_CEILING;
  wire wr_at = wr_en && wr.addr == ADDR_ATTACK;

  // Reserved bits are stored and read back as written; the host keeps
  // them at zero.
  logic [7:0] rd_nxt;
  assign rd_nxt = rd_addr == ADDR_ENABLE_TARGET ? enable_target_r :
                  rd_addr == ADDR_HYST_NOISE ? hyst_noise_r :
                  rd_addr == ADDR_GAIN_CEILING ? gain_ceiling_r :
                  rd_addr == ADDR_ATTACK ? attack_r : 8'h00;

  // One process per register keeps the write decode of each offset apart.
  always_ff @(posedge clock) begin
    if (rst) begin
      enable_target_r <= RST_ENABLE_TARGET;
    end else if (wr_et) begin
      enable_target_r <= wr.data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      hyst_noise_r <= RST_HYST_NOISE;
    end else if (wr_hn) begin
      hyst_noise_r <= wr.data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      gain_ceiling_r <= RST_GAIN_CEILING;
    end else if (wr_gc) begin
      gain_ceiling_r <= wr.data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      attack_r <= RST_ATTACK;
    end else if (wr_at) begin
      attack_r <= wr.data;
    end
  end

  // Read data is registered, so it answers the address of the last clock.
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode into half-dB quantities.

  wire enable = enable_target_r[ENABLE_BIT];
  wire [2:0] target_code = enable_target_r[TARGET_LSB +: 3];
  wire [1:0] hyst_code = hyst_noise_r[HYST_LSB +: 2];
  wire [4:0] noise_code = hyst_noise_r[NOISE_LSB +: 5];
  wire [6:0] ceiling = gain_ceiling_r[6:0];
  wire [4:0] attack_n = attack_r[ATTACK_N_LSB +: 5];
  wire [2:0] attack_m = attack_r[ATTACK_M_LSB +: 3];

  wire [7:0] target = TARGET_HALF_DB[target_code];
  wire [7:0] hyst = HYST_HALF_DB[hyst_code];
  wire [8:0] loud_limit = {1'b0, target} - {1'b0, hyst};
  wire [8:0] quiet_limit = {1'b0, target} + {1'b0, hyst};
  wire [9:0] noise_thr = {2'b00, NOISE_BASE_HALF_DB} +
                         {3'b000, noise_code, 2'b00};
  wire noise_on = noise_code != 5'h00;

  // Base units (2N+1) scaled by 32 samples, then by the multiplier.
  wire [ATTACK_CNT_W-1:0] attack_units =
    {{(ATTACK_CNT_W-6){1'b0}}, attack_n, 1'b1};
  wire [ATTACK_CNT_W-1:0] attack_len =
    (attack_units << ATTACK_UNIT_SHIFT) << attack_m;

  ////////////////////////////////////////////////////////////////////////////
  // Gain tracking loop.

  agc_state_type state_r;
  agc_state_type state_nxt;
  logic [6:0] gain_r;
  logic [6:0] gain_nxt;
  logic noise_hold_r;
  logic step;
  logic active_r;

  // The interval count restarts from zero whenever tracking starts.
  wire timer_run = state_r == ST_TRACK;

  attack_timer #(
    .W(ATTACK_CNT_W)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .run(timer_run),
    .tick(sample_tick),
    .length(attack_len),
    .expire(step)
  );

  // A larger level value is a quieter signal.
  wire too_loud = loud_limit[8] ? 1'b0 : {1'b0, level} < loud_limit;
  wire too_quiet = {1'b0, level} > quiet_limit;
  wire in_noise = noise_on && {2'b00, level} > noise_thr;
  wire over_cap = gain_r > ceiling;
  wire [6:0] gain_down = gain_r - 7'h01;
  wire [6:0] gain_up = gain_r + 7'h01;
  wire lower = step && too_loud && gain_r != 7'h00;
  wire raise = step && too_quiet && !in_noise && gain_r < ceiling;

  always_comb begin
    state_nxt = state_r;
    gain_nxt = gain_r;
    case (state_r)
      ST_OFF: begin
        gain_nxt = 7'h00;
        if (enable) begin
          state_nxt = ST_TRACK;
        end
      end
      ST_TRACK: begin
        if (!enable) begin
          state_nxt = ST_OFF;
          gain_nxt = 7'h00;
        end else if (over_cap) begin
          // A ceiling written below the present gain pulls the gain down
          // at once, without waiting for an attack interval.
          gain_nxt = ceiling;
        end else if (lower) begin
          gain_nxt = gain_down;
        end else if (raise) begin
          gain_nxt = gain_up;
        end
      end
      default: begin
        state_nxt = ST_OFF;
        gain_nxt = 7'h00;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= ST_OFF;
      gain_r <= 7'h00;
      active_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      gain_r <= gain_nxt;
      active_r <= state_nxt == ST_TRACK;
    end
  end

  // The flag lags the level by one clock, like every other output.
  always_ff @(posedge clock) begin
    if (rst) begin
      noise_hold_r <= 1'b0;
    end else begin
      noise_hold_r <= enable && in_noise;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign rd_data = rd_data_r;
  assign gain = gain_r;
  assign noise_hold = noise_hold_r;
  assign active = active_r;

endmodule

/* testbench/agc_core_chk.sv */
// Timing checks on the gain control block's ports.
// Assumes one clock with synchronous active-high reset.
`timescale 1ns/1ps
module agc_core_chk
  import agc_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic rst,
  // Register port.
  input wire logic wr_en,
  input wire agc_pkg::reg_wr_type wr,
  input wire logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  // Record path.
  input wire logic sample_tick,
  input wire logic [7:0] level,
  input wire logic [6:0] gain,
  input wire logic noise_hold,
  input wire logic active
);
  logic [7:0] sh [4];
  wire [7:0] wi = wr.addr - 8'h56;
  wire [7:0] ri = rd_addr - 8'h56;
  wire [7:0] exp_rd = (ri < 8'h04) ? sh[ri[1:0]] : 8'h00;
  wire [6:0] ceil = sh[2][6:0];
  wire [7:0] tg = TARGET_HALF_DB[sh[0][6:4]];
  wire [7:0] hy = HYST_HALF_DB[sh[1][7:6]];
  wire [7:0] thr = NOISE_BASE_HALF_DB + {1'b0, sh[1][5:1], 2'b00};
  wire noisy = (sh[1][5:1] != 5'h00) && (level > thr);
  always_ff @(posedge clock) begin
    if (rst)
      sh <= '{8'h00, 8'h00, 8'h7F, 8'h00};
    else if (wr_en && wi < 8'h04)
      sh[wi[1:0]] <= wr.data;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_reset_clear: assert property (disable iff (1'b0) rst |=>
    gain == 7'h00 && !active && !noise_hold && rd_data == 8'h00)
    else $error("outputs not cleared by reset");
  a_enable_on: assert property (wr_en && wr.addr == 8'h56 &&
    wr.data[7] ##1 !wr_en [*2] |=> active) else $error("enable ignored");
  a_disabled_zero: assert property (!active |-> gain == 7'h00)
    else $error("gain while disabled");
  a_read_data: assert property (!$past(rst) |->
    rd_data == $past(exp_rd)) else $error("read data mismatch");
  a_gain_capped: assert property (gain <= $past(ceil))
    else $error("gain above ceiling");
  a_step_one: assert property (active && gain != $past(gain) |->
    gain == $past(gain) + 7'h01 || gain == $past(gain) - 7'h01 ||
    gain == $past(ceil)) else $error("gain jumped");
  a_lower_cause: assert property (active && gain < $past(gain) &&
    gain != $past(ceil) |-> $past(level) < $past(tg) - $past(hy))
    else $error("gain lowered without cause");
  a_raise_cause: assert property (gain > $past(gain) |->
    $past(level) > $past(tg) + $past(hy) && !$past(noisy))
    else $error("gain raised without cause");
  a_noise_flag: assert property ($past(active) && $past(sh[0][7]) |->
    noise_hold == $past(noisy)) else $error("noise flag wrong");
  cover property (gain > $past(gain));
  cover property (active && gain < $past(gain));
  cover property (noise_hold);
endmodule
bind agc_core agc_core_chk u_agc_core_chk (
  .clock(clock),
  .rst(rst),
  .wr_en(wr_en),
  .wr(wr),
  .rd_addr(rd_addr),
  .rd_data(rd_data),
  .sample_tick(sample_tick),
  .level(level),
  .gain(gain),
  .noise_hold(noise_hold),
  .active(active)
);

/* testbench/adc_automatic_gain_control_test.sv */
// Register and gain loop tests for the gain control block.
// Assumes the block alone, driven at the falling clock edge.
`timescale 1ns/1ps
module adc_automatic_gain_control_test;
  import agc_pkg::*;
  logic clock = 0, rst = 1, wr_en = 0, sample_tick = 0;
  reg_wr_type wr = '0;
  logic [7:0] rd_addr = 8'h00, level = 8'h40, rd_data, th;
  logic [6:0] gain, g;
  logic noise_hold, active;
  int error_cnt = 0, tests_run = 0, n;
  logic [7:0] tg [8] = '{8'h0B, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h22, 8'h28,
    8'h30};
  logic [7:0] hy [4] = '{8'h02, 8'h04, 8'h08, 8'h00};
  always #2.5 clock = ~clock;
  agc_core u_agc_core (.clock(clock), .rst(rst), .wr_en(wr_en), .wr(wr),
    .rd_addr(rd_addr), .rd_data(rd_data), .sample_tick(sample_tick),
    .level(level), .gain(gain), .noise_hold(noise_hold), .active(active));
  task automatic chk(input string w, input logic [15:0] e, logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", w, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr_en = 1;
    wr = '{a, d};
    @(negedge clock);
    wr_en = 0;
    @(negedge clock);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd_addr = a;
    @(negedge clock);
    chk("read data", e, rd_data);
  endtask
  task automatic run(input int lim, output int c);
    logic [6:0] g0;
    g0 = gain;
    c = 0;
    for (int i = 1; i <= lim && c == 0; i++) begin
      @(negedge clock) sample_tick = 1;
      @(negedge clock) sample_tick = 0;
      repeat (2) @(negedge clock);
      if (gain !== g0)
        c = i;
    end
  endtask
  task automatic probe(input logic [7:0] lv, input logic [6:0] d);
    logic [6:0] g0;
    level = lv;
    g0 = gain;
    run(34, n);
    chk("gain", 7'(g0 + d), gain);
  endtask
  task automatic timing(input logic [7:0] att, input int ex);
    wr_reg(8'h56, 8'h00);
    wr_reg(8'h59, att);
    wr_reg(8'h56, 8'h80);
    @(negedge clock);
    chk("active", 1'b1, active);
    run(ex + 8, n);
    chk("attack ticks", ex, n);
    if (n == 0)
      conclude;
  endtask
  task automatic conclude;
    $display("tests run %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clock);
    rst = 0;
    rd_chk(8'h56, 8'h00);
    rd_chk(8'h57, 8'h00);
    rd_chk(8'h58, 8'h7F);
    rd_chk(8'h59, 8'h00);
    wr_reg(8'h5A, 8'hFF);
    rd_chk(8'h5A, 8'h00);
    wr_reg(8'h57, 8'hFE);
    rd_chk(8'h57, 8'hFE);
    wr_reg(8'h57, 8'hC0);
    $display("test registers done");
    timing(8'h09, 192);
    timing(8'h11, 320);
    timing(8'h07, 4096);
    timing(8'h00, 32);
    $display("test attack timing done");
    for (int t = 0; t < 8; t++) begin
      wr_reg(8'h56, {1'b1, 3'(t), 4'h0});
      probe(tg[t] + 8'h01, 7'h01);
      probe(tg[t], 7'h00);
    end
    wr_reg(8'h56, 8'h80);
    for (int h = 0; h < 4; h++) begin
      wr_reg(8'h57, {2'(h), 6'h00});
      probe(8'h0C + hy[h], 7'h01);
      probe(8'h0B + hy[h], 7'h00);
      probe(8'h0A - hy[h], 7'h7F);
    end
    $display("test target and hysteresis done");
    for (int c = 1; c < 32; c += 30) begin
      th = 8'h38 + 8'(4 * c);
      wr_reg(8'h57, {2'b11, 5'(c), 1'b0});
      probe(th + 8'h01, 7'h00);
      chk("noise hold", 1'b1, noise_hold);
      probe(th, 7'h01);
      chk("noise hold", 1'b0, noise_hold);
    end
    g = gain;
    wr_reg(8'h58, {1'b0, g - 7'h01});
    chk("gain", g - 7'h01, gain);
    probe(8'h40, 7'h00);
    wr_reg(8'h56, 8'h00);
    chk("gain", 7'h00, gain);
    chk("active", 1'b0, active);
    $display("test noise ceiling disable done");
    conclude;
  end
endmodule
